//--- logic/eac_pkg.sv
package eac_pkg;
  // ==========================================================
  // Geometry
  localparam int ADDR_W = 32;
  localparam int PAGE_SHIFT = 12;
  localparam int PN_W = ADDR_W - PAGE_SHIFT;
  localparam int NPAGES = 16;
  localparam int IDX_W = 4;
  localparam int OWNER_W = 4;
  localparam int SIZE_W = 3;
  localparam int ATTR_W = 17;

  // ==========================================================
  // Access kinds and page types
  typedef enum logic [2:0] {
    eac_read, eac_write, eac_fetch, eac_ss_load, eac_ss_store
  } eac_kind_type;

  localparam logic [2:0] REGULAR_PAGE_TYPE = 3'h0;
  localparam logic [2:0] THREAD_CONTROL_PAGE_TYPE = 3'h1;
  localparam logic [2:0] TRIMMED_PAGE_TYPE = 3'h2;
  localparam logic [2:0] CONTROL_STRUCTURE_PAGE_TYPE = 3'h3;
  localparam logic [2:0] VERSION_ARRAY_PAGE_TYPE = 3'h4;
  localparam logic [2:0] FIRST_SHADOW_STACK_PAGE_TYPE = 3'h5;
  localparam logic [2:0] LATER_SHADOW_STACK_PAGE_TYPE = 3'h6;

  // ==========================================================
  // Attribute word fields
  localparam int ATTR_R = 0;
  localparam int ATTR_W_BIT = 1;
  localparam int ATTR_X = 2;
  localparam int ATTR_TYPE_LO = 4;
  localparam int PAGE_FLAG_A = 8;
  localparam int PAGE_PENDING = 9;
  localparam int PAGE_FLAG_B = 10;
  localparam int ATTR_OWNER_LO = 12;
  localparam int ATTR_VALID = 16;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] RANGE_BASE_OFS = 8'h04;
  localparam logic [7:0] RANGE_LIMIT_OFS = 8'h08;
  localparam logic [7:0] MAP_INDEX_OFS = 8'h0c;
  localparam logic [7:0] MAP_LINEAR_OFS = 8'h10;
  localparam logic [7:0] MAP_ATTR_OFS = 8'h14;
  localparam logic [7:0] MAP_CTRL_PA_OFS = 8'h18;
  localparam logic [7:0] MAP_CMD_OFS = 8'h1c;
  localparam logic [7:0] STATUS_OFS = 8'h20;
  localparam logic [7:0] THREAD_PA_OFS = 8'h24;
  localparam logic [7:0] FRAME_PA_OFS = 8'h28;

  // ==========================================================
  // Map commands and reset values
  localparam logic [2:0] CMD_PAGE_ADD = 3'h1;
  localparam logic [2:0] CMD_PAGE_AUGMENT = 3'h2;
  localparam logic [2:0] CMD_PAGE_LOAD = 3'h3;
  localparam logic [2:0] CMD_PAGE_REMOVE = 3'h4;
  localparam logic [2:0] CMD_PAGE_WRITE_BACK = 3'h5;
  localparam logic [2:0] CMD_SET_ATTR = 3'h6;
  localparam logic [31:0] RANGE_BASE_RST = 32'h0000_0000;
  localparam logic [31:0] RANGE_LIMIT_RST = 32'h0000_0000;

  // ==========================================================
  // Error code bits
  localparam logic [15:0] ERR_WRITE = 16'h0002;
  localparam logic [15:0] ERR_FETCH = 16'h0010;
  localparam logic [15:0] ENCLAVE_FAULT_ERROR_BIT = 16'h8000;
endpackage

//--- logic/eac_page_map.sv
`timescale 1ns/1ps
module eac_page_map (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [eac_pkg::IDX_W-1:0] wr_idx,
  input wire logic [eac_pkg::ATTR_W-1:0] wr_attr,
  input wire logic [eac_pkg::PN_W-1:0] wr_lin,
  input wire logic [eac_pkg::PN_W-1:0] wr_ctrl_pa,
  input wire logic [eac_pkg::IDX_W-1:0] idx_a,
  input wire logic [eac_pkg::IDX_W-1:0] idx_b,
  input wire logic [eac_pkg::IDX_W-1:0] idx_r,
  output logic [eac_pkg::ATTR_W-1:0] attr_a,
  output logic [eac_pkg::PN_W-1:0] lin_a,
  output logic [eac_pkg::ATTR_W-1:0] attr_b,
  output logic [eac_pkg::PN_W-1:0] lin_b,
  output logic [eac_pkg::ATTR_W-1:0] attr_r,
  output logic [eac_pkg::PN_W-1:0] lin_r,
  output logic [eac_pkg::PN_W-1:0] ctrl_pa_r
);
  import eac_pkg::*;

  logic [ATTR_W-1:0] attr [NPAGES];
  logic [PN_W-1:0] lin [NPAGES];
  logic [PN_W-1:0] ctrl_pa [NPAGES];

  // ==========================================================
  // Storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NPAGES; i++) begin
        attr[i] <= '0;
        lin[i] <= '0;
        ctrl_pa[i] <= '0;
      end
    end else if (wr_en) begin
      attr[wr_idx] <= wr_attr;
      lin[wr_idx] <= wr_lin;
      ctrl_pa[wr_idx] <= wr_ctrl_pa;
    end
  end

  // ==========================================================
  // Lookup ports
  assign attr_a = attr[idx_a];
  assign lin_a = lin[idx_a];
  assign attr_b = attr[idx_b];
  assign lin_b = lin[idx_b];
  assign attr_r = attr[idx_r];
  assign lin_r = lin[idx_r];
  assign ctrl_pa_r = ctrl_pa[idx_r];
endmodule // eac_page_map

//--- logic/eac_checker.sv
`timescale 1ns/1ps
module eac_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic acc_valid,
  input wire eac_pkg::eac_kind_type acc_kind,
  input wire logic [eac_pkg::ADDR_W-1:0] acc_addr,
  input wire logic [eac_pkg::SIZE_W-1:0] acc_size,
  input wire logic [eac_pkg::IDX_W-1:0] acc_page_a,
  input wire logic [eac_pkg::IDX_W-1:0] acc_page_b,
  input wire logic acc_implicit,
  input wire logic acc_explicit,
  input wire logic acc_seg_ok,
  input wire logic acc_paging_ok,
  input wire logic acc_virt_ok,
  output logic fault_valid,
  output logic general_protection_fault,
  output logic page_fault,
  output logic fault_exit,
  output logic [15:0] fault_code,
  output logic alter_access,
  output logic breakpoint_suppress,
  input wire logic enclave_enter,
  input wire logic enclave_resume,
  input wire logic enclave_exit,
  input wire logic asynchronous_exit,
  input wire logic [3:0] seg_usable,
  input wire logic [3:0] seg_base_nonzero,
  output logic entry_fault,
  input wire logic [31:0] fs_in,
  input wire logic [31:0] gs_in,
  input wire logic [31:0] thread_fs,
  input wire logic [31:0] thread_gs,
  input wire logic [31:0] frame_fs_in,
  input wire logic [31:0] frame_gs_in,
  input wire logic [31:0] thread_pa_in,
  input wire logic [31:0] frame_pa_in,
  output logic [31:0] fs_out,
  output logic [31:0] gs_out,
  output logic fs_gs_load,
  output logic [31:0] frame_fs_out,
  output logic [31:0] frame_gs_out,
  output logic frame_wr,
  output logic in_enclave,
  output logic [31:0] thread_pa_cache,
  output logic [31:0] frame_pa_cache,
  output logic pa_cache_valid
);
  import eac_pkg::*;

  logic [OWNER_W-1:0] enclave_id;
  logic [31:0] range_base;
  logic [31:0] range_limit;
  logic [IDX_W-1:0] map_index;
  logic [PN_W-1:0] map_linear;
  logic [ATTR_W-1:0] map_attr;
  logic [PN_W-1:0] map_ctrl_pa;
  logic [31:0] saved_fs;
  logic [31:0] saved_gs;
  logic [ATTR_W-1:0] attr_a;
  logic [ATTR_W-1:0] attr_b;
  logic [ATTR_W-1:0] attr_r;
  logic [PN_W-1:0] lin_a;
  logic [PN_W-1:0] lin_b;
  logic [PN_W-1:0] lin_r;
  logic [PN_W-1:0] ctrl_pa_r;
  logic map_we;
  logic [ATTR_W-1:0] map_wr_attr;
  logic [PN_W-1:0] map_wr_lin;
  logic [PN_W-1:0] map_wr_pa;
  logic [ADDR_W-1:0] acc_end;
  logic in_a;
  logic in_b;
  logic fail_a;
  logic fail_b;
  logic bus_wr;
  logic bus_hit;
  logic [31:0] next_prdata;
  logic entry_ok;

  // ==========================================================
  // Helpers
  function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                    input logic [31:0] base,
                                    input logic [31:0] limit);
    in_range = (a >= base) && (a < limit);
  endfunction

  function automatic logic is_ss(input logic [ATTR_W-1:0] at);
    logic [2:0] t;
    t = at[ATTR_TYPE_LO +: 3];
    is_ss = (t == FIRST_SHADOW_STACK_PAGE_TYPE) ||
            (t == LATER_SHADOW_STACK_PAGE_TYPE);
  endfunction

  // One page part of a direct access
  function automatic logic part_fail(input eac_kind_type k,
                                     input logic [ATTR_W-1:0] at,
                                     input logic [PN_W-1:0] lin,
                                     input logic [ADDR_W-1:0] a,
                                     input logic [OWNER_W-1:0] id);
    logic [2:0] t;
    logic reg_pg;
    logic f;
    t = at[ATTR_TYPE_LO +: 3];
    reg_pg = (t == REGULAR_PAGE_TYPE);
    f = !at[ATTR_VALID];
    f = f || (at[ATTR_OWNER_LO +: OWNER_W] != id);
    if (reg_pg || t == THREAD_CONTROL_PAGE_TYPE || t == TRIMMED_PAGE_TYPE)
      f = f || (lin != a[ADDR_W-1:PAGE_SHIFT]);
    f = f || t == CONTROL_STRUCTURE_PAGE_TYPE ||
         t == THREAD_CONTROL_PAGE_TYPE || t == VERSION_ARRAY_PAGE_TYPE ||
         t == TRIMMED_PAGE_TYPE;
    f = f || at[PAGE_FLAG_A] || at[PAGE_PENDING] || at[PAGE_FLAG_B];
    case (k)
      eac_ss_load, eac_ss_store: f = f || !is_ss(at);
      eac_write: f = f || is_ss(at) || !(at[ATTR_W_BIT] && reg_pg);
      // read needs grant; shadow pages loadable
      eac_read: f = f || !((at[ATTR_R] && reg_pg) || is_ss(at));
      eac_fetch: f = f || !(at[ATTR_X] && reg_pg);
      default: f = 1'b1;
    endcase
    part_fail = f;
  endfunction

  // ==========================================================
  // Page attribute map
  eac_page_map u_map (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(map_we),
    .wr_idx(map_index),
    .wr_attr(map_wr_attr),
    .wr_lin(map_wr_lin),
    .wr_ctrl_pa(map_wr_pa),
    .idx_a(acc_page_a),
    .idx_b(acc_page_b),
    .idx_r(map_index),
    .attr_a(attr_a),
    .lin_a(lin_a),
    .attr_b(attr_b),
    .lin_b(lin_b),
    .attr_r(attr_r),
    .lin_r(lin_r),
    .ctrl_pa_r(ctrl_pa_r)
  );

  assign bus_wr = psel && penable && pwrite;

  // Map command decode
  always_comb begin
    map_we = 1'b0;
    map_wr_attr = map_attr;
    map_wr_lin = map_linear;
    map_wr_pa = map_ctrl_pa;
    if (map_attr[ATTR_TYPE_LO +: 3] != REGULAR_PAGE_TYPE)
      map_wr_attr[ATTR_X:ATTR_R] = 3'h0;
    map_wr_attr[ATTR_VALID] = 1'b1;
    if (bus_wr && paddr == MAP_CMD_OFS) begin
      case (pwdata[2:0])
        CMD_PAGE_ADD, CMD_PAGE_AUGMENT, CMD_PAGE_LOAD: map_we = 1'b1;
        CMD_PAGE_REMOVE, CMD_PAGE_WRITE_BACK: begin
          map_we = 1'b1;
          map_wr_attr = '0;
          map_wr_lin = '0;
          map_wr_pa = '0;
        end
        CMD_SET_ATTR: begin
          map_we = attr_r[ATTR_VALID];
          map_wr_lin = lin_r;
          map_wr_pa = ctrl_pa_r;
        end
        default: map_we = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Access check, combinational so the pipeline can cancel
  assign acc_end = acc_addr + {{(ADDR_W-SIZE_W){1'b0}}, acc_size};
  assign in_a = in_range(acc_addr, range_base, range_limit);
  assign in_b = in_range(acc_end, range_base, range_limit);
  assign fail_a = part_fail(acc_kind, attr_a, lin_a, acc_addr, enclave_id);
  assign fail_b = part_fail(acc_kind, attr_b, lin_b, acc_end, enclave_id);

  always_comb begin
    general_protection_fault = 1'b0;
    page_fault = 1'b0;
    fault_exit = 1'b0;
    fault_code = 16'h0000;
    alter_access = 1'b0;
    breakpoint_suppress = acc_valid && acc_implicit;
    if (!acc_valid || acc_implicit) begin
      fault_code = 16'h0000;
    end else if (!acc_seg_ok) begin
      general_protection_fault = 1'b1;
    end else if (!acc_paging_ok) begin
      page_fault = 1'b1;
      fault_code = (acc_kind == eac_write) ? ERR_WRITE : 16'h0000;
    end else if (acc_explicit && !acc_virt_ok) begin
      fault_exit = 1'b1;
    end else if (in_enclave && !acc_explicit) begin
      if (acc_kind == eac_fetch && !(in_a && in_b)) begin
        general_protection_fault = 1'b1;
      end else if ((acc_kind == eac_ss_load || acc_kind == eac_ss_store)
                   && !(in_a && in_b)) begin
        general_protection_fault = 1'b1;
      end else if ((in_a && fail_a) || (in_b && fail_b)) begin
        page_fault = 1'b1;
        fault_code = ENCLAVE_FAULT_ERROR_BIT;
        if (acc_kind == eac_write || acc_kind == eac_ss_store)
          fault_code = fault_code | ERR_WRITE;
        if (acc_kind == eac_fetch)
          fault_code = fault_code | ERR_FETCH;
      end
    end else if (!in_enclave && !acc_explicit) begin
      // outside accesses are aborted, not faulted
      alter_access = attr_a[ATTR_VALID] || attr_b[ATTR_VALID];
    end
  end

  assign fault_valid = general_protection_fault || page_fault || fault_exit;

  // ==========================================================
  // Entry and exit
  // usable segments need zero base
  assign entry_fault = (enclave_enter || enclave_resume) &&
                       |(seg_usable & seg_base_nonzero);
  assign entry_ok = (enclave_enter || enclave_resume) && !entry_fault;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_enclave <= 1'b0;
    end else if (entry_ok) begin
      in_enclave <= 1'b1;
    end else if (enclave_exit || asynchronous_exit) begin
      in_enclave <= 1'b0;
    end
  end

  // Thread-local segments
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      saved_fs <= '0;
      saved_gs <= '0;
      fs_out <= '0;
      gs_out <= '0;
      fs_gs_load <= 1'b0;
    end else begin
      fs_gs_load <= 1'b0;
      if (entry_ok) begin
        saved_fs <= fs_in;
        saved_gs <= gs_in;
        fs_gs_load <= 1'b1;
        fs_out <= enclave_resume ? frame_fs_in : thread_fs;
        gs_out <= enclave_resume ? frame_gs_in : thread_gs;
      end else if (in_enclave && (enclave_exit || asynchronous_exit)) begin
        fs_out <= saved_fs;
        gs_out <= saved_gs;
        fs_gs_load <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_fs_out <= '0;
      frame_gs_out <= '0;
      frame_wr <= 1'b0;
    end else begin
      frame_wr <= in_enclave && asynchronous_exit && !entry_ok;
      if (in_enclave && asynchronous_exit && !entry_ok) begin
        frame_fs_out <= fs_in;
        frame_gs_out <= gs_in;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thread_pa_cache <= '0;
      frame_pa_cache <= '0;
      pa_cache_valid <= 1'b0;
    // cache at entry, flush at exit
    end else if (entry_ok) begin
      thread_pa_cache <= thread_pa_in;
      frame_pa_cache <= frame_pa_in;
      pa_cache_valid <= 1'b1;
    end else if (enclave_exit || asynchronous_exit) begin
      thread_pa_cache <= '0;
      frame_pa_cache <= '0;
      pa_cache_valid <= 1'b0;
    end
  end

  // ==========================================================
  // APB slave
  always_comb begin
    bus_hit = 1'b1;
    next_prdata = 32'h0000_0000;
    case (paddr)
      CTRL_OFS: next_prdata = {28'h0, enclave_id};
      RANGE_BASE_OFS: next_prdata = range_base;
      RANGE_LIMIT_OFS: next_prdata = range_limit;
      MAP_INDEX_OFS: next_prdata = {28'h0, map_index};
      MAP_LINEAR_OFS: next_prdata = {12'h0, lin_r};
      MAP_ATTR_OFS: next_prdata = {15'h0, attr_r};
      MAP_CTRL_PA_OFS: next_prdata = {12'h0, ctrl_pa_r};
      MAP_CMD_OFS: next_prdata = 32'h0000_0000;
      STATUS_OFS: next_prdata = {30'h0, pa_cache_valid, in_enclave};
      THREAD_PA_OFS: next_prdata = thread_pa_cache;
      FRAME_PA_OFS: next_prdata = frame_pa_cache;
      default: bus_hit = 1'b0;
    endcase
  end

  // Read data captured in setup so it leaves a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
      prdata <= next_prdata;
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !bus_hit;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enclave_id <= '0;
      range_base <= RANGE_BASE_RST;
      range_limit <= RANGE_LIMIT_RST;
      map_index <= '0;
      map_linear <= '0;
      map_attr <= '0;
      map_ctrl_pa <= '0;
    end else if (bus_wr) begin
      case (paddr)
        CTRL_OFS: enclave_id <= pwdata[OWNER_W-1:0];
        RANGE_BASE_OFS: range_base <= pwdata;
        RANGE_LIMIT_OFS: range_limit <= pwdata;
        MAP_INDEX_OFS: map_index <= pwdata[IDX_W-1:0];
        MAP_LINEAR_OFS: map_linear <= pwdata[PN_W-1:0];
        MAP_ATTR_OFS: map_attr <= pwdata[ATTR_W-1:0];
        MAP_CTRL_PA_OFS: map_ctrl_pa <= pwdata[PN_W-1:0];
        default: enclave_id <= enclave_id;
      endcase
    end
  end
endmodule // eac_checker

//--- tb/eac_checker_asserts.sv
`timescale 1ns/1ps
module eac_checker_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic acc_valid,
  input wire logic acc_implicit,
  input wire logic acc_seg_ok,
  input wire logic acc_paging_ok,
  input wire logic fault_valid,
  input wire logic general_protection_fault,
  input wire logic page_fault,
  input wire logic fault_exit,
  input wire logic [15:0] fault_code,
  input wire logic breakpoint_suppress,
  input wire logic enclave_enter,
  input wire logic enclave_resume,
  input wire logic enclave_exit,
  input wire logic asynchronous_exit,
  input wire logic [3:0] seg_usable,
  input wire logic [3:0] seg_base_nonzero,
  input wire logic entry_fault,
  input wire logic [31:0] fs_in,
  input wire logic [31:0] thread_fs,
  input wire logic [31:0] fs_out,
  input wire logic fs_gs_load,
  input wire logic [31:0] frame_fs_out,
  input wire logic frame_wr,
  input wire logic in_enclave,
  input wire logic pa_cache_valid
);
  // ==========================================================
  // Fault reporting
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_one;
    $onehot0({general_protection_fault, page_fault, fault_exit}) &&
      fault_valid == (general_protection_fault || page_fault || fault_exit);
  endproperty
  a_one: assert property (p_one) else $error("fault flags clash");
  property p_gpc;
    general_protection_fault |-> fault_code == 16'h0000;
  endproperty
  a_gpc: assert property (p_gpc) else $error("gp code not zero");
  property p_seg;
    acc_valid && !acc_implicit && !acc_seg_ok |-> general_protection_fault;
  endproperty
  a_seg: assert property (p_seg) else $error("segment fault lost");
  property p_imp;
    acc_valid && acc_implicit |-> !fault_valid && breakpoint_suppress;
  endproperty
  a_imp: assert property (p_imp) else $error("implicit faulted");
  property p_pfc;
    page_fault && acc_seg_ok && acc_paging_ok |-> fault_code[15];
  endproperty
  a_pfc: assert property (p_pfc) else $error("enclave bit clear");
  // ==========================================================
  // Entry and exit
  property p_ent;
    (enclave_enter || enclave_resume) &&
      |(seg_usable & seg_base_nonzero) |-> entry_fault;
  endproperty
  a_ent: assert property (p_ent) else $error("base not refused");
  property p_in;
    enclave_enter && !enclave_resume && !entry_fault |=> in_enclave &&
      fs_gs_load && pa_cache_valid && fs_out == $past(thread_fs);
  endproperty
  a_in: assert property (p_in) else $error("entry state wrong");
  property p_ex;
    in_enclave && enclave_exit && !enclave_enter && !enclave_resume
      |=> !in_enclave && !pa_cache_valid && fs_gs_load;
  endproperty
  a_ex: assert property (p_ex) else $error("exit state wrong");
  property p_aex;
    in_enclave && asynchronous_exit && !enclave_enter && !enclave_resume
      |=> frame_wr && frame_fs_out == $past(fs_in);
  endproperty
  a_aex: assert property (p_aex) else $error("frame save wrong");
  c_gp: cover property (general_protection_fault);
  c_pf: cover property (page_fault);
  c_aex: cover property (frame_wr);
endmodule // eac_checker_chk

bind eac_checker eac_checker_chk i_eac_checker_chk (
  .clk(clk), .rst_n(rst_n), .acc_valid(acc_valid),
  .acc_implicit(acc_implicit), .acc_seg_ok(acc_seg_ok),
  .acc_paging_ok(acc_paging_ok), .fault_valid(fault_valid),
  .general_protection_fault(general_protection_fault),
  .page_fault(page_fault), .fault_exit(fault_exit),
  .fault_code(fault_code), .breakpoint_suppress(breakpoint_suppress),
  .enclave_enter(enclave_enter), .enclave_resume(enclave_resume),
  .enclave_exit(enclave_exit), .asynchronous_exit(asynchronous_exit),
  .seg_usable(seg_usable), .seg_base_nonzero(seg_base_nonzero),
  .entry_fault(entry_fault), .fs_in(fs_in), .thread_fs(thread_fs),
  .fs_out(fs_out), .fs_gs_load(fs_gs_load),
  .frame_fs_out(frame_fs_out), .frame_wr(frame_wr),
  .in_enclave(in_enclave), .pa_cache_valid(pa_cache_valid)
);

//--- tb/eac_pipe_model.sv
`timescale 1ns/1ps
module eac_pipe_model (
  input wire logic clk,
  output logic acc_valid,
  output eac_pkg::eac_kind_type acc_kind,
  output logic [eac_pkg::ADDR_W-1:0] acc_addr,
  output logic [eac_pkg::SIZE_W-1:0] acc_size,
  output logic [eac_pkg::IDX_W-1:0] acc_page_a,
  output logic [eac_pkg::IDX_W-1:0] acc_page_b,
  output logic [4:0] acc_flags
);
  import eac_pkg::*;
  initial begin
    acc_valid = 0;
    acc_kind = eac_read;
    acc_addr = 0;
    acc_size = 0;
    acc_page_a = 0;
    acc_page_b = 0;
    acc_flags = 5'h07;
  end
  // Flags: implicit, explicit, seg ok, paging ok, virt ok
  // operand addresses sit in RBX, RCX, RDX upstream
  task issue(input logic [2:0] k, input logic [31:0] a,
             input logic [2:0] s, input logic [3:0] pa,
             input logic [3:0] pb, input logic [4:0] f);
    @(posedge clk);
    acc_valid <= 1;
    acc_kind <= eac_kind_type'(k);
    acc_addr <= a;
    acc_size <= s;
    acc_page_a <= pa;
    acc_page_b <= pb;
    acc_flags <= f;
    #1;
  endtask
  // Address scrambled when idle so no stale value looks valid
  task idle();
    @(posedge clk);
    acc_valid <= 0;
    acc_addr <= ~acc_addr;
  endtask
endmodule // eac_pipe_model

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import eac_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, a, fs_out, ffo, gso;
  logic pready, pslverr, se, acc_valid, gp, pf, fx, alter, inenc, pcv;
  eac_kind_type acc_kind;
  logic [31:0] acc_addr;
  logic [2:0] acc_size;
  logic [3:0] acc_page_a, acc_page_b, ev = 0, su = 4'hf, sb = 0;
  logic [4:0] fl;
  logic [31:0] w [8];
  int seed = 79522, bad_count = 0, total_checks = 0, k, p;
  eac_checker i_eac_checker (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .acc_valid(acc_valid), .acc_kind(acc_kind), .acc_addr(acc_addr),
    .acc_size(acc_size), .acc_page_a(acc_page_a),
    .acc_page_b(acc_page_b), .acc_implicit(fl[4]), .acc_explicit(fl[3]),
    .acc_seg_ok(fl[2]), .acc_paging_ok(fl[1]), .acc_virt_ok(fl[0]),
    .fault_valid(), .general_protection_fault(gp), .page_fault(pf),
    .fault_exit(fx), .fault_code(), .alter_access(alter),
    .breakpoint_suppress(), .enclave_enter(ev[0]),
    .enclave_resume(ev[1]), .enclave_exit(ev[2]),
    .asynchronous_exit(ev[3]), .seg_usable(su), .seg_base_nonzero(sb),
    .entry_fault(), .fs_in(w[0]), .gs_in(w[1]), .thread_fs(w[2]),
    .thread_gs(w[3]), .frame_fs_in(w[4]), .frame_gs_in(w[5]),
    .thread_pa_in(w[6]), .frame_pa_in(w[7]), .fs_out(fs_out),
    .gs_out(gso), .fs_gs_load(), .frame_fs_out(ffo), .frame_gs_out(),
    .frame_wr(), .in_enclave(inenc), .thread_pa_cache(),
    .frame_pa_cache(),
    .pa_cache_valid(pcv));
  eac_pipe_model i_eac_pipe_model (.clk(clk), .acc_valid(acc_valid),
    .acc_kind(acc_kind), .acc_addr(acc_addr), .acc_size(acc_size),
    .acc_page_a(acc_page_a), .acc_page_b(acc_page_b), .acc_flags(fl));
  initial begin
    forever #10 clk = ~clk;
  end
  // ==========================================================
  // Tasks
  task results();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [71:0] g, input logic [71:0] x);
    total_checks++;
    if (g !== x) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      results();
    end
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task acc(input int k, input logic [31:0] ad, input int s, input int pa,
           input int pb, input logic [4:0] f, input logic [2:0] e);
    i_eac_pipe_model.issue(3'(k), ad, 3'(s), 4'(pa), 4'(pb), f);
    chk({gp, pf, fx}, e);
    i_eac_pipe_model.idle();
  endtask
  task pulse(input int n);
    @(posedge clk);
    ev <= 4'(1 << n);
    @(posedge clk);
    ev <= 0;
    #1;
  endtask
  task st(input logic [31:0] v);
    apb(1, MAP_INDEX_OFS, 0);
    apb(1, MAP_ATTR_OFS, v);
    apb(1, MAP_CMD_OFS, 32'(CMD_SET_ATTR));
  endtask
  // Page 0 regular, 1..4 restricted, 5..6 shadow stack, 7 foreign
  function automatic logic [2:0] ex(int k, int p);
    if (p == 7 || (p > 0 && p < 5)) return 3'b010;
    if (p == 0) return (k > 2) ? 3'b010 : 3'b000;
    return (k == 1 || k == 2) ? 3'b010 : 3'b000;
  endfunction
  // ==========================================================
  // Main sequence
  initial begin
    for (int i = 0; i < 8; i++) w[i] = $random(seed);
    repeat (6) @(posedge clk);
    rst_n <= 1;
    apb(0, STATUS_OFS, 0);
    chk(rd, 0);
    apb(0, RANGE_BASE_OFS, 0);
    chk(rd, RANGE_BASE_RST);
    apb(0, 8'hfc, 0);
    chk(se, 1);
    apb(1, RANGE_BASE_OFS, 32'h10000);
    apb(1, RANGE_LIMIT_OFS, 32'h18000);
    apb(1, CTRL_OFS, 1);
    for (p = 0; p < 8; p++) begin
      apb(1, MAP_INDEX_OFS, p);
      apb(1, MAP_LINEAR_OFS, 32'h10 + p);
      apb(1, MAP_CTRL_PA_OFS, 32'h100 + p);
      apb(1, MAP_ATTR_OFS, ((p == 7 ? 2 : 1) << 12) | ((p % 7) << 4) | 7);
      apb(1, MAP_CMD_OFS, 32'(CMD_PAGE_ADD) + p % 3);
    end
    apb(0, MAP_CTRL_PA_OFS, 0);
    chk(rd, 32'h107);
    sb <= 4'h4;
    pulse(0);
    chk(inenc, 0);
    sb <= 0;
    pulse(0);
    chk({inenc, pcv, fs_out, gso}, {2'b11, w[2], w[3]});
    apb(0, THREAD_PA_OFS, 0);
    chk(rd, w[6]);
    apb(0, FRAME_PA_OFS, 0);
    chk(rd, w[7]);
    repeat (40) begin
      k = $unsigned($random(seed)) % 5;
      p = $unsigned($random(seed)) % 8;
      a = {12'h0, 8'h10 + 8'(p), 12'($random(seed))};
      acc(k, a, 0, p, p, 5'h07, ex(k, p));
    end
    acc(2, 32'h20000, 0, 0, 0, 5'h07, 3'b100);
    acc(3, 32'h0fff0, 0, 0, 0, 5'h07, 3'b100);
    acc(0, 32'h20000, 0, 0, 0, 5'h07, 3'b000);
    acc(2, 32'h17ffe, 3, 7, 7, 5'h07, 3'b100);
    acc(0, 32'h0fffe, 3, 0, 0, 5'h07, 3'b000);
    acc(0, 32'h0fffe, 3, 0, 7, 5'h07, 3'b010);
    acc(0, 32'h11000, 0, 0, 0, 5'h07, 3'b010);
    acc(0, 32'h10000, 0, 0, 0, 5'h03, 3'b100);
    acc(1, 32'h10000, 0, 0, 0, 5'h05, 3'b010);
    acc(0, 32'h10000, 0, 0, 0, 5'h0e, 3'b001);
    acc(0, 32'h17000, 0, 7, 7, 5'h17, 3'b000);
    for (int b = 8; b < 11; b++) begin
      st(32'h1007 | (1 << b));
      acc(0, 32'h10000, 0, 0, 0, 5'h07, 3'b010);
    end
    st(32'h1007);
    pulse(3);
    chk({pcv, ffo, fs_out}, {1'b0, w[0], w[0]});
    pulse(1);
    chk(fs_out, w[4]);
    pulse(2);
    chk({inenc, fs_out}, {1'b0, w[0]});
    i_eac_pipe_model.issue(0, 32'h10000, 0, 0, 0, 5'h07);
    chk(alter, 1);
    i_eac_pipe_model.idle();
    apb(1, MAP_INDEX_OFS, 7);
    apb(1, MAP_CMD_OFS, 32'(CMD_PAGE_REMOVE));
    apb(0, MAP_CTRL_PA_OFS, 0);
    chk(rd, 0);
    apb(0, MAP_ATTR_OFS, 0);
    chk(rd[ATTR_VALID], 0);
    apb(1, MAP_INDEX_OFS, 6);
    apb(1, MAP_CMD_OFS, 32'(CMD_PAGE_WRITE_BACK));
    apb(0, MAP_CTRL_PA_OFS, 0);
    chk(rd, 0);
    results();
  end
endmodule // testbench
